// ### common/fptc_pkg.sv
// constants, register map and state type of the flash protection controller
package fptc_pkg;

  // =========================================================================
  // register offsets (byte addresses on the APB)
  localparam logic [11:0] OFF_ADDR = 12'h000;
  localparam logic [11:0] OFF_DATA = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_RIS  = 12'h00C;
  localparam logic [11:0] OFF_IM   = 12'h010;
  localparam logic [11:0] OFF_MIS  = 12'h014;
  localparam logic [11:0] OFF_RDEN = 12'h130;
  localparam logic [11:0] OFF_PGEN = 12'h134;
  localparam logic [11:0] OFF_USEC = 12'h140;

  // =========================================================================
  // control register fields
  localparam logic [15:0] CTRL_KEY    = 16'hA442;
  localparam int          CTRL_KEY_LO = 16;
  localparam int          CTRL_WRITE  = 0;
  localparam int          CTRL_ERASE  = 1;
  localparam int          CTRL_MERASE = 2;
  localparam int          CTRL_COMMIT = 3;
  localparam int          CTRL_W      = 4;

  // status bits: access (program/erase) violation, read violation
  localparam int RIS_ACC = 0;
  localparam int RIS_RDV = 1;
  localparam int RIS_W   = 2;

  // commit target selected by the address register
  localparam logic [31:0] SEL_RDEN = 32'h0000_0000;
  localparam logic [31:0] SEL_PGEN = 32'h0000_0001;

  // =========================================================================
  // reset values
  localparam logic [7:0]  USEC_RST = 8'h31;
  localparam logic [31:0] PROT_RST = 32'hFFFF_FFFF;
  localparam int          USEC_W   = 8;

  // =========================================================================
  // memory map and geometry
  localparam logic [31:0] SRAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
  localparam int          PAGE_SHIFT = 10;
  localparam int          UNIT_SHIFT = 11;
  localparam int          UNITS      = 32;

  // flash operation time in microseconds
  localparam logic [7:0] OP_TIME_US = 8'd20;

  typedef enum logic [2:0] {
    ST_LOAD, ST_IDLE, ST_WAIT, ST_PROG, ST_ERASE, ST_COMMIT
  } fptc_state_t;

endpackage : fptc_pkg

// ### common/fptc_prot_if.sv
// protection lookup carrier between controller and checker
`timescale 1ns/1ps
interface fptc_prot_if #(parameter int FAW = 16);
  logic [31:0]    pe_bits;
  logic [31:0]    re_bits;
  logic [FAW-1:0] op_addr;
  logic [FAW-1:0] rd_addr;
  logic           op_ok;
  logic           rd_ok;
  modport ctrl (output pe_bits, re_bits, op_addr, rd_addr,
                input  op_ok, rd_ok);
  modport chk  (input  pe_bits, re_bits, op_addr, rd_addr,
                output op_ok, rd_ok);
endinterface : fptc_prot_if

// ### hdl/fptc_prot_chk.sv
// per-unit protection lookup for modify and data-read addresses
`timescale 1ns/1ps
module fptc_prot_chk
  import fptc_pkg::*;
#(
  parameter int FAW = 16
) (
  fptc_prot_if.chk p
);
  // =========================================================================
  // two 1-KB pages share one 2-KB unit, so the unit is the upper bits
  wire [FAW-UNIT_SHIFT-1:0] op_unit = p.op_addr[FAW-1:UNIT_SHIFT];
  wire [FAW-UNIT_SHIFT-1:0] rd_unit = p.rd_addr[FAW-1:UNIT_SHIFT];

  assign p.op_ok = p.pe_bits[op_unit];
  assign p.rd_ok = p.re_bits[rd_unit];
endmodule : fptc_prot_chk

// ### hdl/fptc_ctrl.sv
// flash controller with block protection, sram and bit-band alias decode
`timescale 1ns/1ps
// How it works
// - erase sets every 1-KB page bit to one
// - program one word, only clearing bits
// - two pages form one 2-KB protected unit
// - one program and one read bit per unit
// - program bit one allows modify, zero forbids
// - read bit zero allows execute only
// - execute-only units serve instruction fetch only
// - program one, read zero: modify and fetch, no data reads
// - both bits one: no restriction at all
// - blocked program or page erase flags violation, masked interrupt
// - blocked data read returns zeros
// - writes act now, commit makes permanent
// - uncommitted cleared bits return after power-on
// - microsecond tick from software reload count
// - 64 KB flash, 8 KB sram at base
// - alias word reads or writes one bit
// - commit by keyed write, bit clears when done
module fptc_ctrl
  import fptc_pkg::*;
#(
  parameter int FAW = 16,
  parameter int SAW = 13
) (
  // clock and resets
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        factory_resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // instruction fetch side
  input  wire logic        i_req_i,
  input  wire logic [31:0] i_addr_i,
  output logic             i_valid_o,
  output logic      [31:0] i_rdata_o,
  // data side
  input  wire logic        d_req_i,
  input  wire logic        d_we_i,
  input  wire logic [31:0] d_addr_i,
  input  wire logic [31:0] d_wdata_i,
  output logic             d_valid_o,
  output logic             d_err_o,
  output logic      [31:0] d_rdata_o,
  // interrupt
  output logic             irq_o
);
  localparam int FWW = FAW - 2;
  localparam int SWW = SAW - 2;
  localparam int PGW = PAGE_SHIFT - 2;
  localparam logic [FWW-1:0] PG_MASK = FWW'((1 << PGW) - 1);

  // =========================================================================
  // storage
  logic [31:0] fl_mem [2**FWW];
  logic [31:0] sr_mem [2**SWW];

  fptc_state_t st_ff, nxt_st;
  logic [31:0]       fma_ff, fmd_ff, re_ff, pe_ff;
  logic [31:0]       nv_re_clr_ff, nv_pe_clr_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [RIS_W-1:0]  ris_ff, im_ff;
  logic [USEC_W-1:0] usec_reload_count_ff, usec_cnt_ff, us_left_ff;
  logic [FWW-1:0]    idx_ff, end_ff;
  logic [31:0]       prdata_ff, i_rdata_ff, d_rdata_ff;
  logic pready_ff, pslverr_ff, i_valid_ff, d_valid_ff, d_err_ff, irq_ff;

  fptc_prot_if #(.FAW(FAW)) prot ();

  fptc_prot_chk #(.FAW(FAW)) u_chk (
    .p (prot.chk)
  );

  // =========================================================================
  // apb decode
  wire apb_setup = psel_i & ~penable_i;
  wire apb_acc   = psel_i & penable_i & pready_ff;
  wire apb_wr    = apb_acc & pwrite_i;
  wire wr_addr   = apb_wr & (paddr_i == OFF_ADDR);
  wire wr_data   = apb_wr & (paddr_i == OFF_DATA);
  wire wr_ctrl   = apb_wr & (paddr_i == OFF_CTRL);
  wire wr_im     = apb_wr & (paddr_i == OFF_IM);
  wire wr_mis    = apb_wr & (paddr_i == OFF_MIS);
  wire wr_rden   = apb_wr & (paddr_i == OFF_RDEN);
  wire wr_pgen   = apb_wr & (paddr_i == OFF_PGEN);
  wire wr_usec   = apb_wr & (paddr_i == OFF_USEC);

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (paddr_i)
      OFF_ADDR: rd_mux = fma_ff;
      OFF_DATA: rd_mux = fmd_ff;
      OFF_CTRL: rd_mux = 32'(ctrl_ff);
      OFF_RIS:  rd_mux = 32'(ris_ff);
      OFF_IM:   rd_mux = 32'(im_ff);
      OFF_MIS:  rd_mux = 32'(ris_ff & im_ff);
      OFF_RDEN: rd_mux = re_ff;
      OFF_PGEN: rd_mux = pe_ff;
      OFF_USEC: rd_mux = 32'(usec_reload_count_ff);
      default:  rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~rd_hit;
      if (apb_setup) begin
        prdata_ff <= (pwrite_i | ~rd_hit) ? '0 : rd_mux;
      end
    end
  end

  // =========================================================================
  // microsecond tick: count down from the software reload value
  wire us_tick = (usec_cnt_ff == '0);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      usec_reload_count_ff <= USEC_RST;
      usec_cnt_ff          <= USEC_RST;
    end else begin
      if (wr_usec) begin
        usec_reload_count_ff <= pwdata_i[USEC_W-1:0];
      end
      usec_cnt_ff <= us_tick ? usec_reload_count_ff
                             : usec_cnt_ff - 1'b1;
    end
  end

  // =========================================================================
  // command acceptance and protection lookup
  wire key_ok  = pwdata_i[31:CTRL_KEY_LO] == CTRL_KEY;
  wire is_mod  = pwdata_i[CTRL_WRITE] | pwdata_i[CTRL_ERASE];
  wire cmd_go  = wr_ctrl & key_ok & (st_ff == ST_IDLE)
               & (|pwdata_i[CTRL_W-1:0]);
  wire acc_vio = cmd_go & is_mod & ~prot.op_ok;
  wire cmd_ok  = cmd_go & ~acc_vio;

  wire in_erase = (st_ff == ST_ERASE);
  assign prot.pe_bits = pe_ff;
  assign prot.re_bits = re_ff;
  assign prot.op_addr = in_erase ? {idx_ff, 2'b00} : fma_ff[FAW-1:0];
  assign prot.rd_addr = d_addr_i[FAW-1:0];

  // =========================================================================
  // flash array update; per-word check also keeps mass erase off locked units
  wire [FWW-1:0] fma_word = fma_ff[FAW-1:2];
  wire [31:0]    fl_rd_op = fl_mem[fma_word];
  wire           fl_we    = ((st_ff == ST_PROG) | in_erase)
                          & prot.op_ok;
  wire [FWW-1:0] fl_widx  = in_erase ? idx_ff : fma_word;
  wire [31:0]    fl_wval  = in_erase ? PROT_RST
                                     : fl_rd_op & fmd_ff;

  always_ff @(posedge ref_clk_i) begin
    if (fl_we) begin
      fl_mem[fl_widx] <= fl_wval;
    end
  end

  // =========================================================================
  // operation sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_LOAD:  nxt_st = ST_IDLE;
      ST_IDLE:  if (cmd_ok) nxt_st = ST_WAIT;
      ST_WAIT: begin
        if (us_tick && us_left_ff == '0) begin
          if (ctrl_ff[CTRL_WRITE]) nxt_st = ST_PROG;
          else if (ctrl_ff[CTRL_COMMIT]) nxt_st = ST_COMMIT;
          else nxt_st = ST_ERASE;
        end
      end
      ST_PROG:   nxt_st = ST_IDLE;
      ST_ERASE:  if (idx_ff == end_ff) nxt_st = ST_IDLE;
      ST_COMMIT: nxt_st = ST_IDLE;
    endcase
  end

  wire op_done = (nxt_st == ST_IDLE) & (st_ff != ST_IDLE)
               & (st_ff != ST_LOAD);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff      <= ST_LOAD;
      ctrl_ff    <= '0;
      us_left_ff <= '0;
      idx_ff     <= '0;
      end_ff     <= '0;
    end else begin
      st_ff <= nxt_st;
      if (cmd_ok) begin
        ctrl_ff    <= pwdata_i[CTRL_W-1:0];
        us_left_ff <= OP_TIME_US;
        idx_ff     <= pwdata_i[CTRL_MERASE] ? '0 : fma_word & ~PG_MASK;
        end_ff     <= pwdata_i[CTRL_MERASE] ? '1 : fma_word | PG_MASK;
      end else if (op_done) begin
        ctrl_ff <= '0;
      end
      if (st_ff == ST_WAIT && us_tick && us_left_ff != '0) begin
        us_left_ff <= us_left_ff - 1'b1;
      end
      if (in_erase) begin
        idx_ff <= idx_ff + 1'b1;
      end
    end
  end

  // =========================================================================
  // address and data registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fma_ff <= '0;
      fmd_ff <= '0;
    end else begin
      if (wr_addr && st_ff == ST_IDLE) fma_ff <= pwdata_i;
      if (wr_data && st_ff == ST_IDLE) fmd_ff <= pwdata_i;
    end
  end

  // =========================================================================
  // protection bits: working copy and committed copy
  // committed copy holds cleared bits only; factory reset models a blank part
  wire commit_now = (st_ff == ST_COMMIT);

  always_ff @(posedge ref_clk_i or negedge factory_resetn_i) begin
    if (!factory_resetn_i) begin
      nv_re_clr_ff <= '0;
      nv_pe_clr_ff <= '0;
    end else if (commit_now) begin
      if (fma_ff == SEL_RDEN) nv_re_clr_ff <= nv_re_clr_ff | ~re_ff;
      if (fma_ff == SEL_PGEN) nv_pe_clr_ff <= nv_pe_clr_ff | ~pe_ff;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      re_ff <= PROT_RST;
      pe_ff <= PROT_RST;
    end else if (st_ff == ST_LOAD) begin
      re_ff <= ~nv_re_clr_ff;
      pe_ff <= ~nv_pe_clr_ff;
    end else begin
      // a committed zero cannot be written back to one
      if (wr_rden) re_ff <= pwdata_i & ~nv_re_clr_ff;
      if (wr_pgen) pe_ff <= pwdata_i & ~nv_pe_clr_ff;
    end
  end

  // =========================================================================
  // data side decode: flash, sram and bit-band alias
  wire fl_hit = d_addr_i[31:FAW] == '0;
  wire sr_hit = d_addr_i[31:SAW] == SRAM_BASE[31:SAW];
  wire bb_hit = d_addr_i[31:SAW+5] == ALIAS_BASE[31:SAW+5];
  // alias = base + byte offset * 32 + bit * 4
  wire [SWW-1:0] bb_word = d_addr_i[SAW+4:7];
  wire [4:0]     bb_pos  = {d_addr_i[6:5], d_addr_i[4:2]};
  wire [SWW-1:0] sr_idx  = bb_hit ? bb_word : d_addr_i[SAW-1:2];
  wire [31:0]    sr_rd   = sr_mem[sr_idx];
  wire [31:0]    bb_msk  = 32'h0000_0001 << bb_pos;
  wire [31:0]    sr_wval = bb_hit ? ((sr_rd & ~bb_msk)
                                    | (d_wdata_i[0] ? bb_msk : '0))
                                  : d_wdata_i;
  wire           sr_we   = d_req_i & d_we_i & (sr_hit | bb_hit);
  wire [31:0]    fl_drd  = fl_mem[d_addr_i[FAW-1:2]];
  wire           rd_vio  = d_req_i & ~d_we_i & fl_hit
                         & ~prot.rd_ok;

  always_ff @(posedge ref_clk_i) begin
    if (sr_we) begin
      sr_mem[sr_idx] <= sr_wval;
    end
  end

  logic [31:0] d_mux;
  always_comb begin
    d_mux = '0;
    if (fl_hit) d_mux = prot.rd_ok ? fl_drd : '0;
    else if (sr_hit) d_mux = sr_rd;
    else if (bb_hit) d_mux = 32'(sr_rd[bb_pos]);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      d_valid_ff <= 1'b0;
      d_err_ff   <= 1'b0;
      d_rdata_ff <= '0;
    end else begin
      d_valid_ff <= d_req_i;
      d_err_ff   <= d_req_i & ((fl_hit & d_we_i)
                            | ~(fl_hit | sr_hit | bb_hit));
      if (d_req_i) d_rdata_ff <= d_we_i ? '0 : d_mux;
    end
  end

  // =========================================================================
  // instruction fetch: served whatever the read bit says
  wire i_fl_hit = i_addr_i[31:FAW] == '0;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      i_valid_ff <= 1'b0;
      i_rdata_ff <= '0;
    end else begin
      i_valid_ff <= i_req_i;
      if (i_req_i) begin
        i_rdata_ff <= i_fl_hit ? fl_mem[i_addr_i[FAW-1:2]] : '0;
      end
    end
  end

  // =========================================================================
  // violation status; a new event beats a clear in the same cycle
  wire [RIS_W-1:0] ris_set = {rd_vio, acc_vio};
  wire [RIS_W-1:0] ris_clr = wr_mis ? pwdata_i[RIS_W-1:0] : '0;
  wire [RIS_W-1:0] nxt_ris = (ris_ff & ~ris_clr) | ris_set;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ris_ff <= '0;
      im_ff  <= '0;
      irq_ff <= 1'b0;
    end else begin
      ris_ff <= nxt_ris;
      if (wr_im) im_ff <= pwdata_i[RIS_W-1:0];
      irq_ff <= |(nxt_ris & im_ff);
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign i_valid_o = i_valid_ff;
  assign i_rdata_o = i_rdata_ff;
  assign d_valid_o = d_valid_ff;
  assign d_err_o   = d_err_ff;
  assign d_rdata_o = d_rdata_ff;
  assign irq_o     = irq_ff;

  // =========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_prog_req;
    cmd_ok && pwdata_i[CTRL_WRITE];
  endsequence
  sequence s_idle_free;
    (st_ff == ST_IDLE) && (ctrl_ff == '0);
  endsequence

  AST_ERASE_ONES: assert property (
    (fl_we && in_erase) |-> (fl_wval == PROT_RST))
    else $error("erase wrote a word other than all ones");
  AST_PROG_CLEAR: assert property (
    (fl_we && st_ff == ST_PROG) |-> ((fl_wval & ~fl_rd_op) == '0))
    else $error("program set a bit from zero to one");
  AST_NO_MOD_LOCKED: assert property (
    fl_we |-> pe_ff[fl_widx[FWW-1:UNIT_SHIFT-2]])
    else $error("flash written inside a locked unit");
  AST_ACC_FLAG: assert property (
    (cmd_go && is_mod && !pe_ff[fma_ff[FAW-1:UNIT_SHIFT]])
      |=> ris_ff[RIS_ACC] && st_ff == ST_IDLE)
    else $error("blocked modify not flagged");
  AST_RD_ZERO: assert property (
    (d_req_i && !d_we_i && fl_hit && !re_ff[d_addr_i[FAW-1:UNIT_SHIFT]])
      |=> d_valid_o && d_rdata_o == '0 && ris_ff[RIS_RDV])
    else $error("protected data read returned data");
  AST_FETCH: assert property (
    (i_req_i && i_fl_hit) |=>
      i_valid_o && i_rdata_o == $past(fl_mem[i_addr_i[FAW-1:2]]))
    else $error("fetch not served");
  AST_COMMIT_DONE: assert property (
    (st_ff == ST_COMMIT) |=> s_idle_free)
    else $error("commit bit not cleared after commit");
  AST_PROG_SEQ: assert property (
    s_prog_req |=> (st_ff == ST_WAIT) [*8])
    else $error("program did not wait its timed interval");
  AST_LOAD: assert property (
    (st_ff == ST_LOAD) |=> (re_ff == ~nv_re_clr_ff)
                        && (pe_ff == ~nv_pe_clr_ff))
    else $error("committed protection not loaded");
  AST_PROT_WR: assert property (
    wr_pgen && st_ff != ST_LOAD |=> pe_ff == ($past(pwdata_i)
                                              & ~nv_pe_clr_ff))
    else $error("protection write not applied at once");

endmodule : fptc_ctrl

// ### bench/fptc_cpu_model.sv
// processor fetch and data bus master model for the flash controller
`timescale 1ns/1ps
module fptc_cpu_model (
  // clock
  input  wire logic        ref_clk_i,
  // instruction fetch
  output logic             i_req_o,
  output logic      [31:0] i_addr_o,
  input  wire logic        i_valid_i,
  input  wire logic [31:0] i_rdata_i,
  // data side
  output logic             d_req_o,
  output logic             d_we_o,
  output logic      [31:0] d_addr_o,
  output logic      [31:0] d_wdata_o,
  input  wire logic        d_valid_i,
  input  wire logic        d_err_i,
  input  wire logic [31:0] d_rdata_i
);
  initial begin
    i_req_o   = 1'b0;
    i_addr_o  = 32'h0;
    d_req_o   = 1'b0;
    d_we_o    = 1'b0;
    d_addr_o  = 32'h0;
    d_wdata_o = 32'h0;
  end

  // ==========================================================================
  // data access; released lines carry the inverse so stale values never match
  task automatic dacc(input logic we, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er, output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    er = 1'b0;
    @(posedge ref_clk_i);
    d_req_o   <= 1'b1;
    d_we_o    <= we;
    d_addr_o  <= a;
    d_wdata_o <= wd;
    @(posedge ref_clk_i);
    d_req_o   <= 1'b0;
    d_addr_o  <= ~a;
    d_wdata_o <= ~wd;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk_i);
      if (d_valid_i === 1'b1) begin
        ok = 1'b1;
        rd = d_rdata_i;
        er = d_err_i;
      end
    end
  endtask : dacc

  // ==========================================================================
  // instruction fetch of one word
  task automatic fetch(input logic [31:0] a, output logic [31:0] rd,
                       output logic ok);
    ok = 1'b0;
    rd = 32'h0;
    @(posedge ref_clk_i);
    i_req_o  <= 1'b1;
    i_addr_o <= a;
    @(posedge ref_clk_i);
    i_req_o  <= 1'b0;
    i_addr_o <= ~a;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk_i);
      if (i_valid_i === 1'b1) begin
        ok = 1'b1;
        rd = i_rdata_i;
      end
    end
  endtask : fetch
endmodule : fptc_cpu_model

// ### bench/flash_protect_timing_ctrl_tb.sv
// self-checking bench of the flash protection and timing controller
`timescale 1ns/1ps
module flash_protect_timing_ctrl_tb
  import fptc_pkg::*;
;
  int          seed        = 27;
  int          fails       = 0;
  int          comparisons = 0;
  int          cyc;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        frstn   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, i_addr, i_rdata, d_addr, d_wdata, d_rdata;
  logic [31:0] rd, w1, w2;
  logic        pready, pslverr, irq, i_req, i_valid;
  logic        d_req, d_we, d_valid, d_err, er, ok;

  always #5 clk = ~clk;

  fptc_ctrl #(.FAW(16), .SAW(13)) dut_u (
    .ref_clk_i(clk), .resetn_i(rstn), .factory_resetn_i(frstn),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr),
    .i_req_i(i_req), .i_addr_i(i_addr), .i_valid_o(i_valid),
    .i_rdata_o(i_rdata), .d_req_i(d_req), .d_we_i(d_we),
    .d_addr_i(d_addr), .d_wdata_i(d_wdata), .d_valid_o(d_valid),
    .d_err_o(d_err), .d_rdata_o(d_rdata), .irq_o(irq));

  fptc_cpu_model cpu_u (
    .ref_clk_i(clk), .i_req_o(i_req), .i_addr_o(i_addr),
    .i_valid_i(i_valid), .i_rdata_i(i_rdata), .d_req_o(d_req),
    .d_we_o(d_we), .d_addr_o(d_addr), .d_wdata_o(d_wdata),
    .d_valid_i(d_valid), .d_err_i(d_err), .d_rdata_i(d_rdata));

  // ==========================================================================
  // expectations
  function automatic logic [31:0] alias_of(logic [31:0] off, int b);
    return ALIAS_BASE + (off << 5) + 32'(b * 4);
  endfunction : alias_of

  // one wait of OP_TIME_US+1 ticks, each reload+1 cycles long
  function automatic int op_cyc(int rl);
    return (int'(OP_TIME_US) + 1) * (rl + 1);
  endfunction : op_cyc

  // ==========================================================================
  // checks and closing
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkb(string nm, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chkb

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic alive(logic okv);
    if (okv !== 1'b1) begin
      fails++;
      $display("ERROR handshake expected 1 seen 0");
      conclude();
    end
  endtask : alive

  // ==========================================================================
  // bus cycles
  task automatic apb(logic we, logic [11:0] a, logic [31:0] wd);
    ok = 1'b0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= we;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata;
        er = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
    alive(ok);
  endtask : apb

  task automatic dat(logic we, logic [31:0] a, logic [31:0] wd);
    cpu_u.dacc(we, a, wd, rd, er, ok);
    alive(ok);
  endtask : dat

  task automatic ifetch(logic [31:0] a);
    cpu_u.fetch(a, rd, ok);
    alive(ok);
  endtask : ifetch

  // keyed command, then poll until the control register reads zero
  task automatic fcmd(logic [31:0] a, logic [31:0] d, int bitn);
    logic done;
    done = 1'b0;
    apb(1'b1, OFF_ADDR, a);
    apb(1'b1, OFF_DATA, d);
    apb(1'b1, OFF_CTRL, {CTRL_KEY, 16'h0} | (32'h1 << bitn));
    cyc = 0;
    for (int n = 0; n < 8000 && !done; n++) begin
      apb(1'b0, OFF_CTRL, 32'h0);
      cyc += 3;
      done = (rd === 32'h0);
    end
    alive(done);
  endtask : fcmd

  task automatic power_on(logic factory);
    rstn <= 1'b0;
    frstn <= !factory;
    repeat (12) @(posedge clk);
    rstn  <= 1'b1;
    frstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : power_on

  // ==========================================================================
  // main sequence
  initial begin
    power_on(1'b1);
    apb(1'b0, OFF_USEC, 32'h0);
    chk("usec reload", {24'h0, USEC_RST}, rd);
    apb(1'b0, OFF_RDEN, 32'h0);
    chk("read enables", PROT_RST, rd);
    apb(1'b0, OFF_PGEN, 32'h0);
    chk("program enables", PROT_RST, rd);
    apb(1'b0, 12'hFFC, 32'h0);
    chkb("unmapped error", 1'b1, er);
    $display("test reset values done");
    apb(1'b1, OFF_USEC, 32'h3);
    for (int p = 0; p < 6; p++) begin
      fcmd(32'(p) << PAGE_SHIFT, 32'h0, CTRL_ERASE);
      dat(1'b0, (32'(p) << PAGE_SHIFT) + 32'h3FC, 32'h0);
      chk("erased word", 32'hFFFF_FFFF, rd);
    end
    w1 = $random(seed);
    w2 = $random(seed);
    fcmd(32'h100, w1, CTRL_WRITE);
    chkb("program time", 1'b1,
         cyc >= op_cyc(3) - 6 && cyc <= op_cyc(3) + 12);
    dat(1'b0, 32'h100, 32'h0);
    chk("programmed word", w1, rd);
    fcmd(32'h100, w2, CTRL_WRITE);
    dat(1'b0, 32'h100, 32'h0);
    chk("reprogrammed word", w1 & w2, rd);
    fcmd(32'hC00, w1, CTRL_WRITE);
    $display("test erase and program done");
    apb(1'b1, OFF_IM, 32'h1 << RIS_ACC);
    apb(1'b1, OFF_PGEN, ~32'h2);
    apb(1'b0, OFF_PGEN, 32'h0);
    chk("program enables", ~32'h2, rd);
    fcmd(32'h804, 32'h0, CTRL_WRITE);
    fcmd(32'hC00, 32'h0, CTRL_ERASE);
    dat(1'b0, 32'h804, 32'h0);
    chk("locked word", 32'hFFFF_FFFF, rd);
    dat(1'b0, 32'hC00, 32'h0);
    chk("locked page", w1, rd);
    apb(1'b0, OFF_RIS, 32'h0);
    chk("modify violation", 32'h1 << RIS_ACC, rd & (32'h1 << RIS_ACC));
    chkb("interrupt", 1'b1, irq);
    apb(1'b1, OFF_MIS, 32'h1 << RIS_ACC);
    repeat (2) @(posedge clk);
    chkb("interrupt cleared", 1'b0, irq);
    $display("test program protection done");
    fcmd(32'h1004, w2, CTRL_WRITE);
    apb(1'b1, OFF_RDEN, ~32'h4);
    fcmd(32'h1008, w1, CTRL_WRITE);
    dat(1'b0, 32'h1004, 32'h0);
    chk("read protected", 32'h0, rd);
    ifetch(32'h1004);
    chk("fetch protected", w2, rd);
    ifetch(32'h1008);
    chk("fetch written", w1, rd);
    apb(1'b0, OFF_RIS, 32'h0);
    chk("read violation", 32'h1 << RIS_RDV, rd & (32'h1 << RIS_RDV));
    dat(1'b1, 32'h100, 32'h0);
    chkb("flash write error", 1'b1, er);
    dat(1'b0, 32'h100, 32'h0);
    chk("open unit read", w1 & w2, rd);
    $display("test read protection done");
    fcmd(SEL_RDEN, 32'h0, CTRL_COMMIT);
    apb(1'b1, OFF_PGEN, ~32'h8);
    power_on(1'b0);
    apb(1'b0, OFF_RDEN, 32'h0);
    chk("committed read enables", ~32'h4, rd);
    apb(1'b0, OFF_PGEN, 32'h0);
    chk("restored program enables", PROT_RST, rd);
    dat(1'b0, 32'h1004, 32'h0);
    chk("still read protected", 32'h0, rd);
    apb(1'b1, OFF_PGEN, ~32'h2);
    fcmd(32'h0, 32'h0, CTRL_MERASE);
    dat(1'b0, 32'hC00, 32'h0);
    chk("mass erase locked page", w1, rd);
    dat(1'b0, 32'h100, 32'h0);
    chk("mass erased word", 32'hFFFF_FFFF, rd);
    $display("test commit done");
    for (int k = 0; k < 4; k++) begin
      w1 = $random(seed);
      w2 = {19'h0, w1[12:2], 2'b00};
      dat(1'b1, SRAM_BASE + w2, w1);
      chkb("sram write error", 1'b0, er);
      dat(1'b0, SRAM_BASE + w2, 32'h0);
      chk("sram word", w1, rd);
      dat(1'b1, alias_of(w2, k * 7 + 1), {31'h0, ~w1[k * 7 + 1]});
      dat(1'b0, SRAM_BASE + w2, 32'h0);
      chk("alias write", w1 ^ (32'h1 << (k * 7 + 1)), rd);
      dat(1'b0, alias_of(w2, k * 7 + 1), 32'h0);
      chk("alias read", {31'h0, ~w1[k * 7 + 1]}, rd);
    end
    $display("test sram and alias done");
    conclude();
  end
endmodule : flash_protect_timing_ctrl_tb
